// >>> design/ivp_pkg.sv
// constants shared by the interrupt vector and priority logic
// assumes a 20 MHz bus clock and a 32-bit word-addressed register bus
package ivp_pkg;

  // register word indices on the bus
  localparam logic [1:0] IVP_ADDR_CTRL = 2'h0;
  localparam logic [1:0] IVP_ADDR_PRIO = 2'h1;
  localparam logic [1:0] IVP_ADDR_STAT = 2'h2;
  localparam logic [1:0] IVP_ADDR_MASK = 2'h3;

  // interrupt_control_register fields and reset values, then the priority register reset value
  localparam int IVP_CTRL_EDGE_BIT = 7;
  localparam int IVP_CTRL_PIN_EN_BIT = 6;
  localparam int IVP_CTRL_DELAY_BIT = 5;
  localparam logic IVP_EDGE_RST = 1'b0;
  localparam logic IVP_PIN_EN_RST = 1'b1;
  localparam logic IVP_DELAY_RST = 1'b1;
  localparam logic [7:0] IVP_PRIO_RST = 8'hF2;

  // status / mask register bits
  localparam int IVP_ST_PRIO_REFUSED = 0;
  localparam int IVP_ST_TRAP = 1;
  localparam int IVP_ST_EDGE_LATCH = 2;
  localparam int IVP_ST_STOP_DONE = 3;
  localparam int IVP_ST_W = 4;

  // fixed vectors of the unmaskable sources
  localparam logic [15:0] IVP_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] IVP_VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] IVP_VEC_WATCHDOG = 16'hFFFA;
  localparam logic [15:0] IVP_VEC_TRAP = 16'hFFF8;
  localparam logic [15:0] IVP_VEC_SOFTWARE_INTERRUPT = 16'hFFF6;
  localparam logic [15:0] IVP_VEC_NMI = 16'hFFF4;
  localparam logic [7:0] IVP_VEC_HIGH = 8'hFF;

  // maskable sources in default priority order, value is the vector low byte
  localparam int IVP_NSRC = 16;
  localparam int IVP_SRC_IRQ = 0;
  localparam int IVP_SRC_SCI = 14;
  localparam logic [7:0] IVP_SRC_BYTE [IVP_NSRC] = '{
    8'hF2, 8'hF0, 8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4,
    8'hE2, 8'hE0, 8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD2};

  // oscillator stabilisation wait on stop exit, in bus-clock cycles
  localparam int IVP_STOP_WAIT_CYCLES = 4096;

endpackage : ivp_pkg

// >>> design/ivp_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes the pin is asynchronous to i_clk
`timescale 1ns/1ns
`default_nettype none
module ivp_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // pin and filtered level
  input wire logic i_async,
  output logic o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else if (i_ce) begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      lvl_r <= INIT;
    end else if (i_ce && (s2_r == s3_r)) begin
      lvl_r <= s3_r;
    end
  end

  assign o_level = lvl_r;
endmodule : ivp_sync
`default_nettype wire

// >>> design/ivp_delay.sv
// stop-exit stabilisation wait counter
// assumes i_start is a one-cycle pulse on the bus clock
`timescale 1ns/1ns
`default_nettype none
module ivp_delay #(
  parameter int CYCLES = 4096
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // control
  input wire logic i_start,
  input wire logic i_wait_en,
  // status
  output logic o_busy,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (i_ce) begin
      done_r <= 1'b0;
      if (i_start && !busy_r) begin
        if (i_wait_en) begin
          cnt_r <= LOAD;
          busy_r <= 1'b1;
        end else begin
          done_r <= 1'b1;
        end
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;
endmodule : ivp_delay
`default_nettype wire

// >>> design/ivp_top.sv
// interrupt vectoring and priority logic with its control registers
// assumes the core pulses i_svc_start once per service sequence, and all
// request inputs except the two pins are on i_clk
//
// Overview of operation
// - unmaskable sources get fixed vectors FFFE, FFFC, FFFA, FFF8, FFF6 in that order
// - promotion value of each maskable source equals its vector low byte
// - timer channels, overflow, accumulators, serial transfer vector EE..D8, gated by I
// - serial port at D6 from four enables, converter at D2, D4 reserved
// - nonmaskable pin always level, masked by X; maskable pin level or edge
// - level pins released only in service; vanished request yields trap vector
// - edge mode latches falling edge, latch cleared when that interrupt is serviced
// - other requests are peripheral flags that software clears to avoid trap
// - edge select written once in normal modes; special modes ignore first write
// - edge select 1 means falling edges only, 0 means low level
// - pin enable writable anytime; 1 connects pin, 0 disconnects it
// - stop-exit delay bit written once in normal modes, freely in special
// - delay bit 1 inserts 4096 cycle wait on stop exit, 0 none
// - priority register always readable, writes accepted only while I is 1
// - unimplemented value or above F2 leaves external pin top maskable
// - reset loads priority F2 and level sensing for the external pin
// - promotion keeps other order, vectors, masking and enables unchanged
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ivp_top #(
  parameter int STOP_WAIT = ivp_pkg::IVP_STOP_WAIT_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // avalon-mm slave
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // core state and service handshake
  input wire logic i_special_mode,
  input wire logic i_i_mask,
  input wire logic i_x_mask,
  input wire logic i_svc_start,
  input wire logic i_stop_exit,
  output logic [15:0] o_vector,
  output logic o_vector_valid,
  output logic o_irq_req,
  output logic o_stop_ready,
  // unmaskable sources
  input wire logic i_rst_src,
  input wire logic i_clkmon_fail,
  input wire logic i_watchdog_fail,
  input wire logic i_bad_opcode,
  input wire logic i_software_interrupt,
  // external pins, active low
  input wire logic i_nonmaskable_irq_pin_n,
  input wire logic i_irq_pin_n,
  // peripheral flag requests
  input wire logic i_rti_req,
  input wire logic [7:0] i_timer_req,
  input wire logic i_tov_req,
  input wire logic i_paov_req,
  input wire logic i_paedge_req,
  input wire logic i_spi_req,
  input wire logic [3:0] i_sci_flag,
  input wire logic [3:0] i_sci_en,
  input wire logic i_atd_req,
  // block interrupt
  output logic o_int
);
  localparam int NS = ivp_pkg::IVP_NSRC;

  logic edge_sel_r;
  logic pin_en_r;
  logic delay_r;
  logic edge_wr_r;
  logic delay_wr_r;
  logic [7:0] prio_r;
  logic [ivp_pkg::IVP_ST_W-1:0] stat_r;
  logic [ivp_pkg::IVP_ST_W-1:0] mask_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic nmi_lvl;
  logic irq_lvl;
  logic irq_lvl_d_r;
  logic edge_latch_r;
  logic [15:0] vec_r;
  logic vec_valid_r;
  logic stop_done;
  logic [NS-1:0] req;
  logic [NS-1:0] pend;
  logic promo_hit;
  logic [3:0] promo_idx;
  logic [15:0] vec_nxt;
  logic trap_nxt;
  logic irq_chosen;
  logic bus_req;
  logic wr_en;
  logic wr_ctrl;
  logic wr_prio;
  logic irq_fall;
  logic stop_busy;
  logic [ivp_pkg::IVP_ST_W-1:0] st_ev;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and stop-exit wait

  ivp_sync #(.INIT(1'b1)) u_nmi_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async(i_nonmaskable_irq_pin_n),
    .o_level(nmi_lvl)
  );

  ivp_sync #(.INIT(1'b1)) u_irq_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async(i_irq_pin_n),
    .o_level(irq_lvl)
  );

  ivp_delay #(.CYCLES(STOP_WAIT)) u_stop_wait (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_start(i_stop_exit),
    .i_wait_en(delay_r),
    .o_busy(stop_busy),
    .o_done(stop_done)
  );

  assign o_stop_ready = stop_done;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, write acts at the edge waitrequest is low

  assign bus_req = (i_avs_read || i_avs_write) && i_ce;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
  assign wr_en = i_avs_write && ack_r && i_ce && i_avs_byteenable[0];
  assign wr_ctrl = wr_en && (i_avs_address == ivp_pkg::IVP_ADDR_CTRL);
  assign wr_prio = wr_en && (i_avs_address == ivp_pkg::IVP_ADDR_PRIO);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else if (i_ce) begin
      ack_r <= bus_req && !ack_r;
    end
  end

  // priority register readable at any time, unused upper bits read as zero
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req && !ack_r) begin
      unique case (i_avs_address)
        ivp_pkg::IVP_ADDR_CTRL: rdata_r <= {24'h00_0000, edge_sel_r, pin_en_r, delay_r, 5'h00};
        ivp_pkg::IVP_ADDR_PRIO: rdata_r <= {24'h00_0000, prio_r};
        ivp_pkg::IVP_ADDR_STAT: rdata_r <= {28'h000_0000, stat_r};
        ivp_pkg::IVP_ADDR_MASK: rdata_r <= {28'h000_0000, mask_r};
      endcase
    end
  end

  assign o_avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      edge_sel_r <= ivp_pkg::IVP_EDGE_RST;
      edge_wr_r <= 1'b0;
    end else if (wr_ctrl) begin
      edge_wr_r <= 1'b1;
      // normal: only the first write lands; special: all but the first
      if (i_special_mode ? edge_wr_r : !edge_wr_r) begin
        edge_sel_r <= i_avs_writedata[ivp_pkg::IVP_CTRL_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_en_r <= ivp_pkg::IVP_PIN_EN_RST;
    end else if (wr_ctrl) begin
      pin_en_r <= i_avs_writedata[ivp_pkg::IVP_CTRL_PIN_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      delay_r <= ivp_pkg::IVP_DELAY_RST;
      delay_wr_r <= 1'b0;
    end else if (wr_ctrl) begin
      delay_wr_r <= 1'b1;
      if (i_special_mode || !delay_wr_r) begin
        delay_r <= i_avs_writedata[ivp_pkg::IVP_CTRL_DELAY_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority select register

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prio_r <= ivp_pkg::IVP_PRIO_RST;
    end else if (wr_prio && i_i_mask) begin
      prio_r <= i_avs_writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external maskable pin: level or latched falling edge

  assign irq_fall = irq_lvl_d_r && !irq_lvl;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_lvl_d_r <= 1'b1;
    end else if (i_ce) begin
      irq_lvl_d_r <= irq_lvl;
    end
  end

  // edge is held regardless of later pin level; the latch set wins over clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      edge_latch_r <= 1'b0;
    end else if (i_ce) begin
      if (edge_sel_r && pin_en_r && irq_fall) begin
        edge_latch_r <= 1'b1;
      end else if (!edge_sel_r || (i_svc_start && irq_chosen)) begin
        edge_latch_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request vector and priority resolution

  always_comb begin
    req = '0;
    req[ivp_pkg::IVP_SRC_IRQ] = pin_en_r && (edge_sel_r ? edge_latch_r : !irq_lvl);
    req[1] = i_rti_req;
    req[9:2] = i_timer_req;
    req[10] = i_tov_req;
    req[11] = i_paov_req;
    req[12] = i_paedge_req;
    req[13] = i_spi_req;
    req[ivp_pkg::IVP_SRC_SCI] = |(i_sci_flag & i_sci_en);
    req[15] = i_atd_req;
  end

  assign pend = i_i_mask ? '0 : req;
  assign o_irq_req = |pend;

  // a value matching no implemented source leaves the default order
  always_comb begin
    promo_hit = 1'b0;
    promo_idx = 4'h0;
    for (int k = 0; k < NS; k++) begin
      if (prio_r == ivp_pkg::IVP_SRC_BYTE[k]) begin
        promo_hit = 1'b1;
        promo_idx = 4'(k);
      end
    end
  end

  always_comb begin
    vec_nxt = ivp_pkg::IVP_VEC_TRAP;
    trap_nxt = 1'b0;
    irq_chosen = 1'b0;
    if (i_rst_src) begin
      vec_nxt = ivp_pkg::IVP_VEC_RESET;
    end else if (i_clkmon_fail) begin
      vec_nxt = ivp_pkg::IVP_VEC_CLKMON;
    end else if (i_watchdog_fail) begin
      vec_nxt = ivp_pkg::IVP_VEC_WATCHDOG;
    end else if (i_bad_opcode) begin
      vec_nxt = ivp_pkg::IVP_VEC_TRAP;
    end else if (i_software_interrupt) begin
      vec_nxt = ivp_pkg::IVP_VEC_SOFTWARE_INTERRUPT;
    end else if (!nmi_lvl && !i_x_mask) begin
      vec_nxt = ivp_pkg::IVP_VEC_NMI;
    end else if (promo_hit && pend[promo_idx]) begin
      vec_nxt = {ivp_pkg::IVP_VEC_HIGH, ivp_pkg::IVP_SRC_BYTE[promo_idx]};
      irq_chosen = (promo_idx == 4'(ivp_pkg::IVP_SRC_IRQ));
    end else if (|pend) begin
      for (int k = NS - 1; k >= 0; k--) begin
        if (pend[k]) begin
          vec_nxt = {ivp_pkg::IVP_VEC_HIGH, ivp_pkg::IVP_SRC_BYTE[k]};
          irq_chosen = (k == ivp_pkg::IVP_SRC_IRQ);
        end
      end
    end else begin
      trap_nxt = 1'b1;
    end
  end

  // vector captured at the start of the service sequence
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      vec_r <= ivp_pkg::IVP_VEC_RESET;
      vec_valid_r <= 1'b0;
    end else if (i_ce) begin
      vec_valid_r <= i_svc_start;
      if (i_svc_start) begin
        vec_r <= vec_nxt;
      end
    end
  end

  assign o_vector = vec_r;
  assign o_vector_valid = vec_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt output

  always_comb begin
    st_ev = '0;
    st_ev[ivp_pkg::IVP_ST_PRIO_REFUSED] = wr_prio && !i_i_mask;
    st_ev[ivp_pkg::IVP_ST_TRAP] = i_svc_start && trap_nxt;
    st_ev[ivp_pkg::IVP_ST_EDGE_LATCH] = edge_sel_r && pin_en_r && irq_fall;
    st_ev[ivp_pkg::IVP_ST_STOP_DONE] = stop_done;
  end

  // an event wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stat_r <= '0;
    end else if (i_ce) begin
      for (int b = 0; b < ivp_pkg::IVP_ST_W; b++) begin
        if (st_ev[b]) begin
          stat_r[b] <= 1'b1;
        end else if (wr_en && i_avs_address == ivp_pkg::IVP_ADDR_STAT && i_avs_writedata[b]) begin
          stat_r[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mask_r <= '0;
    end else if (wr_en && i_avs_address == ivp_pkg::IVP_ADDR_MASK) begin
      mask_r <= i_avs_writedata[ivp_pkg::IVP_ST_W-1:0];
    end
  end

  assign o_int = |(stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  reset_vec_a: assert property (i_ce && i_svc_start && i_rst_src |=> o_vector == 16'hFFFE)
    else $error("reset vector not selected");
  soft_int_vec_a: assert property (i_ce && i_svc_start && !i_rst_src && !i_clkmon_fail
      && !i_watchdog_fail && !i_bad_opcode && i_software_interrupt |=> o_vector == 16'hFFF6 && o_vector_valid)
    else $error("software interrupt vector wrong");
  masked_vec_a: assert property (i_ce && i_svc_start && i_i_mask |=> o_vector[7:0] >= 8'hF4)
    else $error("maskable vector while globally masked");
  trap_vec_a: assert property (i_ce && i_svc_start && trap_nxt |=> o_vector == 16'hFFF8 && stat_r[1])
    else $error("empty service did not take trap");
  promote_vec_a: assert property (i_ce && i_svc_start && vec_nxt[15:8] == 8'hFF && promo_hit
      && pend[promo_idx] && vec_nxt[7:0] < 8'hF4 |=> o_vector[7:0] == $past(prio_r))
    else $error("promoted source not first");
  edge_latch_a: assert property (i_ce && edge_sel_r && pin_en_r && irq_fall ##1 !i_svc_start [*2]
      |-> edge_latch_r)
    else $error("falling edge not held");
  prio_lock_a: assert property (wr_prio && !i_i_mask |=> $stable(prio_r))
    else $error("priority write accepted while unmasked");
  edge_once_a: assert property (wr_ctrl && !i_special_mode && edge_wr_r |=> $stable(edge_sel_r))
    else $error("edge select rewritten in normal mode");
  delay_off_a: assert property (i_ce && i_stop_exit && !delay_r && !stop_busy |=> o_stop_ready)
    else $error("stop exit delayed without delay bit");
  delay_on_a: assert property (i_ce && i_stop_exit && delay_r && !stop_busy |=> !o_stop_ready [*8])
    else $error("stop exit wait skipped");

  promote_c: cover property (i_svc_start && promo_hit && promo_idx != 4'h0 && pend[promo_idx]);
  edge_c: cover property (edge_latch_r ##1 i_svc_start && irq_chosen);
  trap_c: cover property (i_svc_start && trap_nxt);
  stop_c: cover property (stop_busy ##1 o_stop_ready);
endmodule : ivp_top
`default_nettype wire

// >>> verification/ivp_pin_agent.sv
// model of the external agent on the two interrupt pins
// assumes service is seen as the core's vector valid pulse on i_clk
`timescale 1ns/1ns
`default_nettype none
module ivp_pin_agent (
  // clock
  input wire logic i_clk,
  // commands from the bench
  input wire logic i_raise_irq,
  input wire logic i_raise_nmi,
  input wire logic i_edge_mode,
  // service seen at the core side
  input wire logic i_svc_seen,
  // pins, active low
  output logic o_irq_pin_n,
  output logic o_nmi_pin_n
);
  logic hold_r = 1'b0;
  logic [2:0] pulse_r = 3'h0;
  // a level request is held until a service sequence runs
  always_ff @(posedge i_clk) begin
    if (i_raise_irq && !i_edge_mode) hold_r <= 1'b1;
    else if (i_svc_seen) hold_r <= 1'b0;
  end
  // an edge request is a short low pulse, then the pull-up wins
  always_ff @(posedge i_clk) begin
    if (i_raise_irq && i_edge_mode) pulse_r <= 3'h6;
    else if (pulse_r != 3'h0) pulse_r <= pulse_r - 3'h1;
  end
  assign o_irq_pin_n = !(hold_r || pulse_r != 3'h0);
  assign o_nmi_pin_n = !i_raise_nmi;
endmodule : ivp_pin_agent
`default_nettype wire

// >>> verification/ivp_top_tb.sv
// self-checking bench for the interrupt vector and priority logic
// assumes the bench plays core, peripherals and bus master; the agent drives the pins
`timescale 1ns/1ns
`default_nettype none
module ivp_top_tb;
  localparam int STOP_W = 8;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] adr = 2'h0;
  logic rd = 1'b0, wr = 1'b0, spec = 1'b0, imask = 1'b1, xmask = 1'b1, svc = 1'b0, stp = 1'b0, ce = 1'b1;
  logic raise = 1'b0, nmi = 1'b0, edge_md = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [4:0] um = 5'h0;
  logic [15:0] req = 16'h0;
  logic [3:0] sflag = 4'h0, sen = 4'h0;
  logic [15:0] vec;
  logic wreq, vld, irq, sready, intr, pin_n, nmi_n;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #25 i_clk = ~i_clk;
  ivp_top #(.STOP_WAIT(STOP_W)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'h1), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_special_mode(spec), .i_i_mask(imask), .i_x_mask(xmask), .i_svc_start(svc),
    .i_stop_exit(stp), .o_vector(vec), .o_vector_valid(vld), .o_irq_req(irq), .o_stop_ready(sready),
    .i_rst_src(um[0]), .i_clkmon_fail(um[1]), .i_watchdog_fail(um[2]), .i_bad_opcode(um[3]),
    .i_software_interrupt(um[4]), .i_nonmaskable_irq_pin_n(nmi_n), .i_irq_pin_n(pin_n),
    .i_rti_req(req[1]), .i_timer_req(req[9:2]), .i_tov_req(req[10]), .i_paov_req(req[11]),
    .i_paedge_req(req[12]), .i_spi_req(req[13]), .i_sci_flag(sflag), .i_sci_en(sen),
    .i_atd_req(req[15]), .o_int(intr));
  ivp_pin_agent agent (.i_clk(i_clk), .i_raise_irq(raise), .i_raise_nmi(nmi), .i_edge_mode(edge_md),
    .i_svc_seen(vld), .o_irq_pin_n(pin_n), .o_nmi_pin_n(nmi_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // one bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge i_clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wb(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wb
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask : rchk
  task automatic sv(input logic [15:0] exp);
    @(posedge i_clk);
    svc <= 1'b1;
    @(posedge i_clk);
    svc <= 1'b0;
    @(negedge i_clk);
    chk({vld, vec}, {1'b1, exp});
  endtask : sv
  task automatic pin_fall(input int n);
    @(posedge i_clk);
    raise <= 1'b1;
    @(posedge i_clk);
    raise <= 1'b0;
    tick(n);
  endtask : pin_fall
  task automatic do_reset(input logic sm);
    @(posedge i_clk);
    i_reset <= 1'b1;
    spec <= sm;
    edge_md <= 1'b0;
    tick(3);
    i_reset <= 1'b0;
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(vec, ivp_pkg::IVP_VEC_RESET);
    rchk(ivp_pkg::IVP_ADDR_CTRL, 8'h60);
    rchk(ivp_pkg::IVP_ADDR_PRIO, 8'hF2);
    rchk(ivp_pkg::IVP_ADDR_STAT, 8'h00);
    rchk(ivp_pkg::IVP_ADDR_MASK, 8'h00);
  endtask : t_reset
  task automatic t_stop(input int exp);
    int n;
    @(posedge i_clk);
    stp <= 1'b1;
    @(posedge i_clk);
    stp <= 1'b0;
    n = 1;
    @(negedge i_clk);
    while (sready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    chk(n, exp);
  endtask : t_stop
  task automatic t_unmask();
    logic [15:0] uv [5] = '{ivp_pkg::IVP_VEC_RESET, ivp_pkg::IVP_VEC_CLKMON, ivp_pkg::IVP_VEC_WATCHDOG,
      ivp_pkg::IVP_VEC_TRAP, ivp_pkg::IVP_VEC_SOFTWARE_INTERRUPT};
    @(posedge i_clk);
    um <= 5'h1F;
    for (int i = 0; i < 5; i++) begin
      sv(uv[i]);
      @(posedge i_clk);
      um[i] <= 1'b0;
    end
    nmi <= 1'b1;
    xmask <= 1'b0;
    tick(8);
    sv(ivp_pkg::IVP_VEC_NMI);
    @(posedge i_clk);
    xmask <= 1'b1;
    sv(ivp_pkg::IVP_VEC_TRAP);
    @(posedge i_clk);
    nmi <= 1'b0;
  endtask : t_unmask
  task automatic t_order();
    logic [15:0] m;
    @(posedge i_clk);
    imask <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      m = 16'hFFFF << k;
      @(posedge i_clk);
      req <= m;
      sflag <= {3'h0, m[14]};
      sen <= 4'hF;
      if (k == 0) pin_fall(8);
      @(negedge i_clk);
      chk(irq, 1'b1);
      sv({ivp_pkg::IVP_VEC_HIGH, ivp_pkg::IVP_SRC_BYTE[k]});
      // let the released pin pass the synchroniser
      if (k == 0) tick(6);
    end
    @(posedge i_clk);
    imask <= 1'b1;
    @(negedge i_clk);
    chk(irq, 1'b0);
    sv(ivp_pkg::IVP_VEC_TRAP);
  endtask : t_order
  task automatic t_sci();
    @(posedge i_clk);
    req <= 16'h0;
    imask <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      @(posedge i_clk);
      sflag <= 4'h1 << j;
      sen <= 4'h1 << j;
      sv(16'hFFD6);
      @(posedge i_clk);
      sen <= ~(4'h1 << j);
      sv(ivp_pkg::IVP_VEC_TRAP);
    end
    @(posedge i_clk);
    sflag <= 4'h0;
  endtask : t_sci
  task automatic t_promote();
    logic [7:0] bad [2] = '{8'hD4, 8'hF4};
    logic [31:0] q;
    @(posedge i_clk);
    req <= 16'hFFFE;
    imask <= 1'b1;
    wb(ivp_pkg::IVP_ADDR_PRIO, 8'hDA);
    rchk(ivp_pkg::IVP_ADDR_PRIO, 8'hDA);
    imask <= 1'b0;
    pin_fall(8);
    sv(16'hFFDA);
    tick(6);
    @(posedge i_clk);
    req <= 16'hEFFE;
    sv(16'hFFF0);
    wb(ivp_pkg::IVP_ADDR_STAT, 8'h0F);
    wb(ivp_pkg::IVP_ADDR_PRIO, 8'hF0);
    rchk(ivp_pkg::IVP_ADDR_PRIO, 8'hDA);
    bus(1'b0, ivp_pkg::IVP_ADDR_STAT, 8'h00, q);
    chk(q[ivp_pkg::IVP_ST_PRIO_REFUSED], 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      imask <= 1'b1;
      wb(ivp_pkg::IVP_ADDR_PRIO, bad[i]);
      imask <= 1'b0;
      pin_fall(8);
      sv(16'hFFF2);
    end
  endtask : t_promote
  task automatic t_trap_int();
    @(posedge i_clk);
    req <= 16'h0;
    wb(ivp_pkg::IVP_ADDR_STAT, 8'h0F);
    wb(ivp_pkg::IVP_ADDR_MASK, 8'h02);
    sv(ivp_pkg::IVP_VEC_TRAP);
    @(negedge i_clk);
    chk(intr, 1'b1);
    wb(ivp_pkg::IVP_ADDR_MASK, 8'h00);
    @(negedge i_clk);
    chk(intr, 1'b0);
    wb(ivp_pkg::IVP_ADDR_MASK, 8'h02);
    @(negedge i_clk);
    chk(intr, 1'b1);
    wb(ivp_pkg::IVP_ADDR_STAT, 8'h02);
    @(negedge i_clk);
    chk(intr, 1'b0);
  endtask : t_trap_int
  task automatic t_edge();
    wb(ivp_pkg::IVP_ADDR_CTRL, 8'hC0);
    rchk(ivp_pkg::IVP_ADDR_CTRL, 8'hC0);
    wb(ivp_pkg::IVP_ADDR_CTRL, 8'h20);
    rchk(ivp_pkg::IVP_ADDR_CTRL, 8'h80);
    t_stop(1);
    @(posedge i_clk);
    edge_md <= 1'b1;
    pin_fall(10);
    sv(ivp_pkg::IVP_VEC_TRAP);
    wb(ivp_pkg::IVP_ADDR_CTRL, 8'hC0);
    pin_fall(12);
    sv(16'hFFF2);
    sv(ivp_pkg::IVP_VEC_TRAP);
  endtask : t_edge
  task automatic t_freeze();
    @(posedge i_clk);
    ce <= 1'b0;
    svc <= 1'b1;
    @(posedge i_clk);
    svc <= 1'b0;
    ce <= 1'b1;
    @(negedge i_clk);
    chk({vld, vec}, {1'b0, ivp_pkg::IVP_VEC_TRAP});
  endtask : t_freeze
  task automatic t_special();
    do_reset(1'b1);
    wb(ivp_pkg::IVP_ADDR_CTRL, 8'hE0);
    rchk(ivp_pkg::IVP_ADDR_CTRL, 8'h60);
    wb(ivp_pkg::IVP_ADDR_CTRL, 8'hC0);
    rchk(ivp_pkg::IVP_ADDR_CTRL, 8'hC0);
    wb(ivp_pkg::IVP_ADDR_CTRL, 8'hA0);
    rchk(ivp_pkg::IVP_ADDR_CTRL, 8'hA0);
  endtask : t_special
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    t_reset();
    t_stop(STOP_W + 1);
    t_unmask();
    t_order();
    t_sci();
    t_promote();
    t_trap_int();
    t_edge();
    t_freeze();
    t_special();
    complete_run();
  end
endmodule : ivp_top_tb
`default_nettype wire
